// ==== core/port_function_select_pkg.sv ====
// Package with register map, field layout, codes and pin positions of the pin function select
package port_function_select_pkg;

   // ==========================================================================
   // Register indices (byte address is four times the index)
   // ==========================================================================
   localparam logic [7:0]  IDX_SERIAL_PIN_SELECT    = 8'h04;
   localparam logic [7:0]  IDX_MISCELLANEOUS        = 8'h0c;
   localparam logic [7:0]  IDX_TIMER_B_PIN_SELECT   = 8'h13;
   localparam logic [7:0]  IDX_TIMER_C_PIN_SELECT   = 8'h14;
   localparam logic [7:0]  IDX_INTERRUPT_PIN_SELECT = 8'h24;
   localparam logic [7:0]  IDX_DATA_CONTROL_R0      = 8'h30;
   localparam logic [7:0]  IDX_DATA_CONTROL_R1      = 8'h31;
   localparam logic [7:0]  IDX_DATA_CONTROL_R2      = 8'h32;
   localparam logic [7:0]  IDX_PORT_DATA_R0         = 8'h40;
   localparam logic [7:0]  IDX_PORT_DATA_R1         = 8'h41;
   localparam logic [7:0]  IDX_PORT_DATA_R2         = 8'h42;
   localparam logic [7:0]  IDX_PIN_LEVEL_STATUS     = 8'h43;

   // ==========================================================================
   // Byte addresses on the APB
   // ==========================================================================
   localparam logic [11:0] ADDR_SERIAL_PIN_SELECT    = {2'b00, IDX_SERIAL_PIN_SELECT, 2'b00};
   localparam logic [11:0] ADDR_MISCELLANEOUS        = {2'b00, IDX_MISCELLANEOUS, 2'b00};
   localparam logic [11:0] ADDR_TIMER_B_PIN_SELECT   = {2'b00, IDX_TIMER_B_PIN_SELECT, 2'b00};
   localparam logic [11:0] ADDR_TIMER_C_PIN_SELECT   = {2'b00, IDX_TIMER_C_PIN_SELECT, 2'b00};
   localparam logic [11:0] ADDR_INTERRUPT_PIN_SELECT = {2'b00, IDX_INTERRUPT_PIN_SELECT, 2'b00};
   localparam logic [11:0] ADDR_DATA_CONTROL_R0      = {2'b00, IDX_DATA_CONTROL_R0, 2'b00};
   localparam logic [11:0] ADDR_DATA_CONTROL_R1      = {2'b00, IDX_DATA_CONTROL_R1, 2'b00};
   localparam logic [11:0] ADDR_DATA_CONTROL_R2      = {2'b00, IDX_DATA_CONTROL_R2, 2'b00};
   localparam logic [11:0] ADDR_PORT_DATA_R0         = {2'b00, IDX_PORT_DATA_R0, 2'b00};
   localparam logic [11:0] ADDR_PORT_DATA_R1         = {2'b00, IDX_PORT_DATA_R1, 2'b00};
   localparam logic [11:0] ADDR_PORT_DATA_R2         = {2'b00, IDX_PORT_DATA_R2, 2'b00};
   localparam logic [11:0] ADDR_PIN_LEVEL_STATUS     = {2'b00, IDX_PIN_LEVEL_STATUS, 2'b00};

   // ==========================================================================
   // Widths, reset values and field positions
   // ==========================================================================
   localparam int          NUM_PINS           = 12;
   localparam int          NUM_IRQ            = 3;
   localparam logic [1:0]  TB_SEL_RESET       = 2'h0;
   localparam logic [2:0]  TC_SEL_RESET       = 3'h0;
   localparam logic [2:0]  IRQ_SEL_RESET      = 3'h0;
   localparam logic [1:0]  SERIAL_SEL_RESET   = 2'h0;
   localparam logic [3:0]  NIBBLE_RESET       = 4'h0;
   localparam int          MISC_PULLUP_BIT    = 3;
   localparam int          SERIAL_TX_BIT      = 0;
   localparam int          SERIAL_RX_BIT      = 1;

   // Pin positions: R0 in 3..0, R1 in 7..4, R2 in 11..8
   localparam int          PIN_IRQ1           = 0;
   localparam int          PIN_TIMER_B        = 4;
   localparam int          PIN_TIMER_C        = 5;
   localparam int          PIN_TIMER_D        = 6;
   localparam int          PIN_SERIAL_RX      = 10;
   localparam int          PIN_SERIAL_TX      = 11;

   // ==========================================================================
   // Timer output select codes
   // ==========================================================================
   localparam logic [1:0]  TB_PORT            = 2'h0;
   localparam logic [1:0]  TB_TOGGLE          = 2'h1;
   localparam logic [1:0]  TB_ZERO            = 2'h2;
   localparam logic [1:0]  TB_ONE             = 2'h3;
   localparam logic [2:0]  TC_PORT            = 3'h0;
   localparam logic [2:0]  TC_TOGGLE          = 3'h1;
   localparam logic [2:0]  TC_ZERO            = 3'h2;
   localparam logic [2:0]  TC_ONE             = 3'h3;
   localparam logic [2:0]  TC_PWM             = 3'h7;

endpackage

// ==== core/pin_level_sync.sv ====
// Two-stage synchroniser for the port pin input levels
`timescale 1ns/1ps

module pin_level_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             sys_clk_in,
   input  wire logic             reset_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_q;

   // ==========================================================================
   // Synchroniser
   // ==========================================================================
   // First stage feeds only the second; nothing else may look at it
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         stage1_q <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1_q <= async_in;
         sync_out <= stage1_q;
      end
   end

endmodule // pin_level_sync

// ==== core/port_function_select_pullup.sv ====
// Port pin function select and pull-up control behind an APB slave
// Overview of operation
// (RULE_01) Interrupt pin select: write-only bits 0-2, reset 0, 1 makes R0 pin IRQ input.
// (RULE_02) Timer C select at 0x14: read/write 3-bit field, resets to 000.
// (RULE_03) Timer C codes: port, toggle, zero, one, PWM(111); 100-110 inhibited.
// (RULE_04) Timer B select at 0x13: 2-bit field, 00 port, 01 toggle, 10 zero.
// (RULE_05) Serial select write-only: bit 1 makes R2.2 data in, bit 0 R2.3 data out.
// (RULE_06) Every I/O pin has a program-controlled pull-up; input-only pins have none.
// (RULE_07) Miscellaneous register bit 3 switches all pull-ups together.
// (RULE_08) Each pin's output data bit also gates its own pull-up.
// (RULE_09) Pull-up control and function selection are independent settings.
// (RULE_10) Timer B, C, D outputs appear on R1 pins 0-2 only when selected.
// (RULE_11) Timer B code 11 gives a constant one output.
// (RULE_12) Pull-up on only when global enable and pin data bit are both 1.
`timescale 1ns/1ps

module port_function_select_pullup
(
   input  wire logic                                       sys_clk_in,
   input  wire logic                                       reset_in,
   input  wire logic [11:0]                                paddr_in,
   input  wire logic                                       psel_in,
   input  wire logic                                       penable_in,
   input  wire logic                                       pwrite_in,
   input  wire logic [31:0]                                pwdata_in,
   output logic      [31:0]                                prdata_out,
   output logic                                            pready_out,
   output logic                                            pslverr_out,
   input  wire logic [port_function_select_pkg::NUM_PINS-1:0] pin_in,
   output logic      [port_function_select_pkg::NUM_PINS-1:0] pin_data_out,
   output logic      [port_function_select_pkg::NUM_PINS-1:0] pin_oe_out,
   output logic      [port_function_select_pkg::NUM_PINS-1:0] pin_pullup_out,
   input  wire logic                                       tb_toggle_in,
   input  wire logic                                       tc_toggle_in,
   input  wire logic                                       tc_pwm_in,
   input  wire logic                                       td_value_in,
   input  wire logic                                       td_select_in,
   input  wire logic                                       serial_tx_data_in,
   output logic                                            serial_rx_data_out,
   output logic      [port_function_select_pkg::NUM_IRQ-1:0]  ext_irq_out
);

   import port_function_select_pkg::*;

   // ==========================================================================
   // Declarations
   // ==========================================================================
   logic [1:0]          tb_sel_q;
   logic [2:0]          tc_sel_q;
   logic [2:0]          irq_sel_q;
   logic [1:0]          serial_sel_q;
   logic                pullup_en_q;
   logic [NUM_PINS-1:0] dcr_q;
   logic [NUM_PINS-1:0] pdr_q;
   logic                pready_q;
   logic                pslverr_q;
   logic [31:0]         prdata_q;
   logic [NUM_PINS-1:0] pin_data_q;
   logic [NUM_PINS-1:0] pin_oe_q;
   logic [NUM_PINS-1:0] pin_pullup_q;
   logic                serial_rx_q;
   logic [NUM_IRQ-1:0]  ext_irq_q;
   logic [NUM_PINS-1:0] pin_sync;
   logic [NUM_PINS-1:0] pin_data_d;
   logic [NUM_PINS-1:0] pin_pullup_d;
   logic [NUM_IRQ-1:0]  ext_irq_d;
   logic                serial_rx_d;

   wire                 setup_phase;
   wire                 access_done;
   wire                 wr_en;
   wire                 hit_serial;
   wire                 hit_misc;
   wire                 hit_tmb;
   wire                 hit_tmc;
   wire                 hit_irq;
   wire                 hit_dcr0;
   wire                 hit_dcr1;
   wire                 hit_dcr2;
   wire                 hit_pdr0;
   wire                 hit_pdr1;
   wire                 hit_pdr2;
   wire                 hit_stat;
   wire                 mapped;
   wire [3:0]           wr_nib;
   wire [3:0]           misc_rd;
   wire [3:0]           rd_nib;
   wire                 tob_active;
   wire                 tob_value;
   wire                 toc_active;
   wire                 toc_value;

   // ==========================================================================
   // Pin input synchroniser
   // ==========================================================================
   pin_level_sync #(.WIDTH(NUM_PINS)) u_pin_sync
   (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .async_in   (pin_in),
      .sync_out   (pin_sync)
   );

   // ==========================================================================
   // APB decode
   // ==========================================================================
   // Zero wait state: data is latched in setup, pready follows in access
   assign setup_phase = psel_in & ~penable_in;
   assign access_done = psel_in & penable_in & pready_q;
   assign wr_en       = access_done & pwrite_in & ~pslverr_q;
   assign wr_nib      = pwdata_in[3:0];

   // Address compare, one named wire per register
   assign hit_serial = (paddr_in == ADDR_SERIAL_PIN_SELECT);
   assign hit_misc   = (paddr_in == ADDR_MISCELLANEOUS);
   assign hit_tmb    = (paddr_in == ADDR_TIMER_B_PIN_SELECT);
   assign hit_tmc    = (paddr_in == ADDR_TIMER_C_PIN_SELECT);
   assign hit_irq    = (paddr_in == ADDR_INTERRUPT_PIN_SELECT);
   assign hit_dcr0   = (paddr_in == ADDR_DATA_CONTROL_R0);
   assign hit_dcr1   = (paddr_in == ADDR_DATA_CONTROL_R1);
   assign hit_dcr2   = (paddr_in == ADDR_DATA_CONTROL_R2);
   assign hit_pdr0   = (paddr_in == ADDR_PORT_DATA_R0);
   assign hit_pdr1   = (paddr_in == ADDR_PORT_DATA_R1);
   assign hit_pdr2   = (paddr_in == ADDR_PORT_DATA_R2);
   assign hit_stat   = (paddr_in == ADDR_PIN_LEVEL_STATUS);
   assign mapped     = hit_serial | hit_misc | hit_tmb | hit_tmc | hit_irq | hit_dcr0
                     | hit_dcr1 | hit_dcr2 | hit_pdr0 | hit_pdr1 | hit_pdr2 | hit_stat;

   // Read data; write-only selects and data control read back as zero
   assign misc_rd = 4'(pullup_en_q) << MISC_PULLUP_BIT;
   assign rd_nib  = hit_tmb  ? {2'b00, tb_sel_q} :               // RULE_04
                    hit_tmc  ? {1'b0, tc_sel_q} :                // RULE_02
                    hit_misc ? misc_rd :
                    hit_pdr0 ? pdr_q[3:0] :
                    hit_pdr1 ? pdr_q[7:4] :
                    hit_pdr2 ? pdr_q[11:8] :
                    hit_stat ? pin_sync[3:0] :
                    NIBBLE_RESET;

   // Bus answer registers; reads are sampled once, in setup
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end
      else
      begin
         pready_q  <= setup_phase;
         pslverr_q <= setup_phase & ~mapped;
         if (setup_phase)
            prdata_q <= {28'h0, rd_nib};
      end
   end

   // ==========================================================================
   // Function select registers
   // ==========================================================================
   // Inhibited timer C codes are stored as written; they behave as port use
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         tb_sel_q     <= TB_SEL_RESET;                                // RULE_04
         tc_sel_q     <= TC_SEL_RESET;                                // RULE_02
         irq_sel_q    <= IRQ_SEL_RESET;                               // RULE_01
         serial_sel_q <= SERIAL_SEL_RESET;                            // RULE_05
      end
      else if (wr_en)
      begin
         if (hit_tmb)
            tb_sel_q <= wr_nib[1:0];                                  // RULE_04
         if (hit_tmc)
            tc_sel_q <= wr_nib[2:0];                                  // RULE_02
         if (hit_irq)
            irq_sel_q <= wr_nib[2:0];                                 // RULE_01
         if (hit_serial)
            serial_sel_q <= wr_nib[1:0];                              // RULE_05
      end
   end

   // ==========================================================================
   // Pull-up enable, data control and port data registers
   // ==========================================================================
   // Kept apart from the select registers so neither write disturbs the other
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         pullup_en_q <= 1'b0;
         dcr_q       <= '0;
         pdr_q       <= '0;
      end
      else if (wr_en)
      begin
         if (hit_misc)
            pullup_en_q <= wr_nib[MISC_PULLUP_BIT];                   // RULE_07
         if (hit_dcr0)
            dcr_q[3:0] <= wr_nib;
         if (hit_dcr1)
            dcr_q[7:4] <= wr_nib;
         if (hit_dcr2)
            dcr_q[11:8] <= wr_nib;
         if (hit_pdr0)
            pdr_q[3:0] <= wr_nib;                                     // RULE_08
         if (hit_pdr1)
            pdr_q[7:4] <= wr_nib;                                     // RULE_08
         if (hit_pdr2)
            pdr_q[11:8] <= wr_nib;                                    // RULE_08
      end
   end

   // ==========================================================================
   // Timer output decode
   // ==========================================================================
   // Code 11 of timer B is taken as constant one, like timer C
   assign tob_active = (tb_sel_q != TB_PORT);                          // RULE_10
   assign tob_value  = (tb_sel_q == TB_TOGGLE) ? tb_toggle_in
                                               : (tb_sel_q == TB_ONE); // RULE_11
   assign toc_active = (tc_sel_q == TC_TOGGLE) | (tc_sel_q == TC_ZERO)
                     | (tc_sel_q == TC_ONE) | (tc_sel_q == TC_PWM);     // RULE_03
   assign toc_value  = (tc_sel_q == TC_TOGGLE) ? tc_toggle_in :
                       (tc_sel_q == TC_PWM)    ? tc_pwm_in :
                       (tc_sel_q == TC_ONE);                           // RULE_03

   // ==========================================================================
   // Pin output mux
   // ==========================================================================
   // Port data is the default; a selected function overrides only its own pin
   always_comb
   begin
      pin_data_d = pdr_q;                                             // RULE_09
      if (tob_active)
         pin_data_d[PIN_TIMER_B] = tob_value;                         // RULE_10
      if (toc_active)
         pin_data_d[PIN_TIMER_C] = toc_value;                         // RULE_10
      if (td_select_in)
         pin_data_d[PIN_TIMER_D] = td_value_in;                       // RULE_10
      if (serial_sel_q[SERIAL_TX_BIT])
         pin_data_d[PIN_SERIAL_TX] = serial_tx_data_in;               // RULE_05
   end

   // Pull-up uses the stored port data, never the muxed value
   assign pin_pullup_d = {NUM_PINS{pullup_en_q}} & pdr_q;             // RULE_12

   // Peripheral inputs idle high when the pin is left as a port
   always_comb
   begin
      for (int i = 0; i < NUM_IRQ; i++)
         ext_irq_d[i] = irq_sel_q[i] ? pin_sync[PIN_IRQ1 + i] : 1'b1;  // RULE_01
   end
   assign serial_rx_d = serial_sel_q[SERIAL_RX_BIT] ? pin_sync[PIN_SERIAL_RX]
                                                    : 1'b1;           // RULE_05

   // ==========================================================================
   // Output registers
   // ==========================================================================
   // Every pin here is an I/O pin, so each carries a pull-up control
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         pin_data_q   <= '0;
         pin_oe_q     <= '0;
         pin_pullup_q <= '0;
         serial_rx_q  <= 1'b1;
         ext_irq_q    <= '1;
      end
      else
      begin
         pin_data_q   <= pin_data_d;
         pin_oe_q     <= dcr_q;
         pin_pullup_q <= pin_pullup_d;                                // RULE_06
         serial_rx_q  <= serial_rx_d;
         ext_irq_q    <= ext_irq_d;
      end
   end

   assign prdata_out         = prdata_q;
   assign pready_out         = pready_q;
   assign pslverr_out        = pslverr_q;
   assign pin_data_out       = pin_data_q;
   assign pin_oe_out         = pin_oe_q;
   assign pin_pullup_out     = pin_pullup_q;
   assign serial_rx_data_out = serial_rx_q;
   assign ext_irq_out        = ext_irq_q;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   // A timer C select write, then a read of it after one idle bus cycle
   sequence s_write_tmc;
      access_done && pwrite_in && hit_tmc;
   endsequence

   property p_irq_port_idle;
      @(posedge sys_clk_in) disable iff (reset_in)
      !irq_sel_q[0] |=> ext_irq_out[0];
   endproperty
   a_irq_port_idle: assert property (p_irq_port_idle)                 // RULE_01
      else $error("irq1 output active while pin is a port");

   property p_tmc_readback;
      @(posedge sys_clk_in) disable iff (reset_in)
      s_write_tmc ##2 (psel_in && !penable_in && hit_tmc) |=>
         prdata_out[2:0] == $past(pwdata_in[2:0], 3);
   endproperty
   a_tmc_readback: assert property (p_tmc_readback)                   // RULE_02
      else $error("timer C select did not read back written value");

   property p_toc_one;
      @(posedge sys_clk_in) disable iff (reset_in)
      (tc_sel_q == TC_ONE) |=> pin_data_out[PIN_TIMER_C];
   endproperty
   a_toc_one: assert property (p_toc_one)                             // RULE_03
      else $error("timer C constant one not on pin");

   property p_toc_zero;
      @(posedge sys_clk_in) disable iff (reset_in)
      (tc_sel_q == TC_ZERO) |=> !pin_data_out[PIN_TIMER_C];
   endproperty
   a_toc_zero: assert property (p_toc_zero)                           // RULE_03
      else $error("timer C constant zero not on pin");

   property p_tob_port;
      @(posedge sys_clk_in) disable iff (reset_in)
      (tb_sel_q == TB_PORT) |=> pin_data_out[PIN_TIMER_B] == $past(pdr_q[PIN_TIMER_B]);
   endproperty
   a_tob_port: assert property (p_tob_port)                           // RULE_04
      else $error("timer B pin not following port data");

   property p_tob_one;
      @(posedge sys_clk_in) disable iff (reset_in)
      (tb_sel_q == TB_ONE) |=> pin_data_out[PIN_TIMER_B];
   endproperty
   a_tob_one: assert property (p_tob_one)                             // RULE_11
      else $error("timer B code 11 not constant one");

   property p_serial_tx;
      @(posedge sys_clk_in) disable iff (reset_in)
      serial_sel_q[SERIAL_TX_BIT] |=>
         pin_data_out[PIN_SERIAL_TX] == $past(serial_tx_data_in);
   endproperty
   a_serial_tx: assert property (p_serial_tx)                         // RULE_05
      else $error("serial data out not on its pin");

   property p_pullup_gate;
      @(posedge sys_clk_in) disable iff (reset_in)
      ##1 pin_pullup_out == ($past(pdr_q) & {NUM_PINS{$past(pullup_en_q)}});
   endproperty
   a_pullup_gate: assert property (p_pullup_gate)                     // RULE_12
      else $error("pull-up not equal to global enable and port data");

   property p_global_off;
      @(posedge sys_clk_in) disable iff (reset_in)
      !pullup_en_q ##1 !pullup_en_q |-> pin_pullup_out == '0;
   endproperty
   a_global_off: assert property (p_global_off)                       // RULE_07
      else $error("pull-up on while globally disabled");

   property p_select_keeps_pullup;
      @(posedge sys_clk_in) disable iff (reset_in)
      (wr_en && (hit_tmb || hit_tmc || hit_irq || hit_serial)) ##1 1'b1 |=>
         $stable(pin_pullup_out);
   endproperty
   a_select_keeps_pullup: assert property (p_select_keeps_pullup)     // RULE_09
      else $error("function select write changed a pull-up");

   property p_timer_d_gate;
      @(posedge sys_clk_in) disable iff (reset_in)
      !td_select_in |=> pin_data_out[PIN_TIMER_D] == $past(pdr_q[PIN_TIMER_D]);
   endproperty
   a_timer_d_gate: assert property (p_timer_d_gate)                   // RULE_10
      else $error("timer D drives pin while not selected");

endmodule // port_function_select_pullup

// ==== verification/periph_partner_model.sv ====
// Partner model: timer waveforms and serial transmit bit seen by the pin mux
`timescale 1ns/1ps
module periph_partner_model
(
   input  wire logic sys_clk_in,
   input  wire logic reset_in,
   output logic      tb_toggle_out,
   output logic      tc_toggle_out,
   output logic      tc_pwm_out,
   output logic      serial_tx_out
);
   logic [2:0] wave_q;
   // ==========================================================================
   // Waveforms
   // Distinct rates per timer source so a crossed mux leg shows at the pin
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
         wave_q <= 3'h0;
      else
         wave_q <= wave_q + 3'h1;
   end
   // Transmit bit mirrors a timer rate but inverted, so it never aliases it
   assign tb_toggle_out = wave_q[0];
   assign tc_toggle_out = wave_q[1];
   assign tc_pwm_out    = wave_q[2];
   assign serial_tx_out = ~wave_q[1];
endmodule // periph_partner_model

// ==== verification/tb_port_function_select_pullup.sv ====
// Self-checking bench for the port function select and pull-up block
`timescale 1ns/1ps
module tb_port_function_select_pullup;
   import port_function_select_pkg::*;
   logic        sys_clk_in = 0, reset_in = 1, psel = 0, penable = 0, pwrite = 0;
   logic        td_val = 0, td_sel = 0, pready, err, perr, rx, tbt, tct, pwm, tx;
   logic [11:0] paddr = 0, pin_in = 0, pin_data, pull, oe;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [3:0]  src_q;
   logic [2:0]  irq, tcs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
   int          failures = 0, samples_checked = 0, cycles = 0;
   // ==========================================================================
   // Clock, source history and hang guard
   initial forever #2.5 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) src_q <= {tx, pwm, tct, tbt};
   always @(posedge sys_clk_in) if (++cycles == 5000) begin failures++; complete_run(); end
   port_function_select_pullup uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
      .pin_in(pin_in), .pin_data_out(pin_data), .pin_oe_out(oe), .pin_pullup_out(pull),
      .tb_toggle_in(tbt), .tc_toggle_in(tct), .tc_pwm_in(pwm), .td_value_in(td_val),
      .td_select_in(td_sel), .serial_tx_data_in(tx), .serial_rx_data_out(rx),
      .ext_irq_out(irq));
   periph_partner_model peer (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .tb_toggle_out(tbt), .tc_toggle_out(tct), .tc_pwm_out(pwm), .serial_tx_out(tx));
   // ==========================================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Holds the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge sys_clk_in);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge sys_clk_in);
      penable <= 1;
      do @(posedge sys_clk_in); while (pready !== 1'b1);
      rd = prdata; err = perr;
      psel <= 0; penable <= 0;
   endtask
   task automatic settle;
      repeat (4) @(negedge sys_clk_in);
   endtask
   // Port value where the code leaves the pin to the port data
   function automatic logic sel_exp(input logic [2:0] c, input logic tog, input logic pb);
      case (c)
         3'h1: return tog;
         3'h2: return 1'b0;
         3'h3: return 1'b1;
         3'h7: return src_q[2];
         default: return pb;
      endcase
   endfunction
   // ==========================================================================
   // Scenarios
   task automatic test_timers;
      apb(0, ADDR_TIMER_B_PIN_SELECT, 0); check(rd, TB_SEL_RESET);
      apb(0, ADDR_TIMER_C_PIN_SELECT, 0); check(rd, TC_SEL_RESET);
      apb(1, ADDR_PORT_DATA_R1, 32'h5);
      td_sel <= 1; td_val <= 0;
      for (int i = 0; i < 6; i++)
      begin
         apb(1, ADDR_TIMER_C_PIN_SELECT, {29'h0, tcs[i]});
         apb(0, ADDR_TIMER_C_PIN_SELECT, 0); check(rd, tcs[i]);
         apb(1, ADDR_TIMER_B_PIN_SELECT, 32'(i[1:0]));
         apb(0, ADDR_TIMER_B_PIN_SELECT, 0); check(rd, i[1:0]);
         settle();
         check(pin_data[PIN_TIMER_C], sel_exp(tcs[i], src_q[1], 1'b0));
         check(pin_data[PIN_TIMER_B], sel_exp({1'b0, i[1:0]}, src_q[0], 1'b1));
      end
      check(pin_data[PIN_TIMER_D], 1'b0);
      $display("timer select test done");
   endtask
   task automatic test_pullup;
      check(pull, 12'h0);
      apb(1, ADDR_PORT_DATA_R1, 32'ha);
      apb(1, ADDR_MISCELLANEOUS, 32'h8);
      apb(1, ADDR_TIMER_B_PIN_SELECT, 32'(TB_ONE));
      apb(1, ADDR_DATA_CONTROL_R1, 32'h6);
      settle(); check(pull, 12'h0a0);
      check(oe, 12'h060);
      check(pin_data[PIN_TIMER_B], 1'b1);
      apb(1, ADDR_MISCELLANEOUS, 0);
      settle(); check(pull, 12'h0);
      $display("pull-up test done");
   endtask
   task automatic test_irq_serial;
      @(posedge sys_clk_in);
      pin_in <= 12'h402;
      apb(1, ADDR_INTERRUPT_PIN_SELECT, 32'h7);
      apb(1, ADDR_SERIAL_PIN_SELECT, 32'h3);
      settle(); check(irq, 3'h2); check(rx, 1'b1);
      @(posedge sys_clk_in);
      pin_in <= 12'h005;
      settle(); check(irq, 3'h5); check(rx, 1'b0);
      apb(0, ADDR_PIN_LEVEL_STATUS, 0); check(rd, 32'h5);
      check(pin_data[PIN_SERIAL_TX], src_q[3]);
      apb(0, ADDR_INTERRUPT_PIN_SELECT, 0); check(rd, 0);
      apb(1, ADDR_INTERRUPT_PIN_SELECT, 0);
      settle(); check(irq, 3'h7);
      apb(0, 12'hffc, 0); check(err, 1'b1); check(rd, 0);
      $display("interrupt and serial test done");
   endtask
   initial
   begin
      repeat (4) @(posedge sys_clk_in);
      reset_in <= 0;
      test_timers();
      test_pullup();
      test_irq_serial();
      complete_run();
   end
endmodule // tb_port_function_select_pullup
